// >>> pin_partner.sv
// Controller model driving the control pins and the nibble host port
`timescale 1ns/100ps
module pin_partner (
  input  wire logic       pclk,
  input  wire logic [3:0] data_out,
  input  wire logic       data_oe_n,
  output logic            go_pulse_n,
  output logic            halt_pulse_n,
  output logic            pause_pulse_n,
  output logic            put_strobe_n,
  output logic            fetch_strobe_n,
  output logic            chip_enable_n,
  output logic [3:0]      data_in,
  output logic            stuck
);
  logic [4:0] low;
  // Strobes idle high, one bit each: go, halt, pause, put, fetch
  assign {fetch_strobe_n, put_strobe_n, pause_pulse_n, halt_pulse_n, go_pulse_n} = ~low;
  initial begin
    low = 5'h00;
    chip_enable_n = 1'b1;
    data_in = 4'h0;
    stuck = 1'b0;
  end
  // Low pulse of len cycles, then a high gap of three
  task automatic pulse(input int idx, input int len);
    @(posedge pclk) low[idx] <= 1'b1;
    repeat (len) @(posedge pclk);
    low[idx] <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  // Fetch with the given chip enable; the nibble is taken once it has settled
  task automatic peek(input logic ce_n, output logic [3:0] v, output logic oe_n);
    @(posedge pclk) chip_enable_n <= ce_n;
    low[4] <= 1'b1;
    repeat (5) @(posedge pclk);
    v = data_out;
    oe_n = data_oe_n;
    low[4] <= 1'b0;
    chip_enable_n <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  // Poll busy until clear, then put one nibble
  task automatic put_cmd(input logic [3:0] nib);
    logic [3:0] v;
    logic       oe;
    int         n;
    n = 0;
    do begin
      peek(1'b0, v, oe);
      n++;
    end while (v[0] !== 1'b0 && n < 400);
    if (n >= 400) stuck = 1'b1;
    chip_enable_n <= 1'b0;
    data_in <= nib;
    pulse(3, 3);
    data_in <= ~nib; // Released lines show the inverse of the last nibble
    chip_enable_n <= 1'b1;
  endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the voice recorder control block
`timescale 1ns/100ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, policy, rate, vte, dir, voice;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd, prdata;
  logic [4:0]  sel;
  logic [3:0]  dout, din, nib;
  logic        pready, slv, err, oe, act, pdn, osc, pull, tick, stuck;
  logic        go_n, halt_n, pause_n, put_n, fetch_n, ce_n;
  int          miscompares, total_checks, gap;
  voice_recorder_control voice_recorder_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(slv),
    .go_pulse_n(go_n), .halt_pulse_n(halt_n), .pause_pulse_n(pause_n),
    .put_strobe_n(put_n), .fetch_strobe_n(fetch_n), .chip_enable_n(ce_n),
    .sleep_policy_select(policy), .rate_select(rate), .voice_trigger_enable(vte),
    .direction_select(dir), .word_count_sel_lo(sel[3]), .word_count_sel_hi(sel[4]),
    .channel_bit0(sel[0]), .channel_bit1(sel[1]), .channel_bit2(sel[2]),
    .voice_detect(voice), .data_in(din), .data_out(dout), .data_oe_n(oe),
    .activity_flag(act), .powered_down(pdn), .osc_enable(osc), .pullup_enable(pull),
    .sample_tick(tick), .mem_addr(), .mem_write(), .mem_read());
  pin_partner pin_partner_inst (
    .pclk(pclk), .data_out(dout), .data_oe_n(oe), .go_pulse_n(go_n), .halt_pulse_n(halt_n),
    .pause_pulse_n(pause_n), .put_strobe_n(put_n), .fetch_strobe_n(fetch_n),
    .chip_enable_n(ce_n), .data_in(din), .stuck(stuck));
  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // A wait that runs out counts as a mismatch and closes the run
  task automatic hang(input string nm);
    miscompares++;
    $display("[ERR] %s expected event seen timeout", nm);
    end_of_test();
  endtask
  // One APB transfer: setup, then access until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) hang("pready");
    rd = prdata;
    err = slv;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic state_is(input logic [4:0] e);
    apb(1'b0, voice_recorder_pkg::OFS_STATUS, 32'h0000_0000);
    chk("state", {27'h0, rd[8:4]}, {27'h0, e});
  endtask
  // Cycles from one sample tick to the next
  task automatic tick_gap();
    for (gap = 0; gap < 2000 && tick !== 1'b1; gap++) @(posedge pclk);
    gap = 0;
    do begin
      @(posedge pclk);
      gap++;
    end while (tick !== 1'b1 && gap < 2000);
  endtask
  task automatic wait_act(input logic lvl);
    int i;
    for (i = 0; i < 20000 && act !== lvl; i++) @(posedge pclk);
    if (i >= 20000) hang("activity_flag");
  endtask
  // Free-running clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, policy, rate, vte, voice} = 8'h00;
    {dir, paddr, pwdata, sel} = {1'b1, 8'h00, 32'h0000_0000, 5'h00};
    miscompares = 0;
    total_checks = 0;
    repeat (4) @(posedge pclk);
    chk("powered_down", pdn, 1'b1);
    chk("osc_enable", osc, 1'b0);
    chk("pullup_enable", pull, 1'b0);
    presetn <= 1'b1;
    apb(1'b0, voice_recorder_pkg::OFS_CONFIG, 32'h0000_0000);
    chk("config", rd, {30'h0, voice_recorder_pkg::CFG_RESET});
    chk("pullup_enable", pull, 1'b1);
    chk("powered_down", pdn, 1'b1);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk("unmapped error", err, 1'b1);
    chk("unmapped data", rd, 32'h0000_0000);
    $display("reset test done");
    pin_partner_inst.pulse(0, 3);
    chk("activity", act, 1'b1);
    chk("powered_down", pdn, 1'b0);
    state_is(voice_recorder_pkg::s_rec);
    chk("start addr", {16'h0, rd[31:16]}, {16'h0, voice_recorder_pkg::VOICE_BASE});
    tick_gap();
    chk("gap slow", gap, 768);
    rate <= 1'b1;
    tick_gap();
    tick_gap();
    chk("gap fast", gap, 512);
    pin_partner_inst.pulse(2, 3);
    state_is(voice_recorder_pkg::s_pause);
    chk("activity", act, 1'b1);
    vte <= 1'b1;
    pin_partner_inst.pulse(0, 3);
    state_is(voice_recorder_pkg::s_rec);
    pin_partner_inst.pulse(1, 3);
    state_is(voice_recorder_pkg::s_idle);
    chk("activity", act, 1'b0);
    chk("powered_down", pdn, 1'b1);
    pin_partner_inst.pulse(0, 3);
    state_is(voice_recorder_pkg::s_wait);
    pin_partner_inst.pulse(1, 3);
    state_is(voice_recorder_pkg::s_idle);
    pin_partner_inst.pulse(0, 3);
    voice <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("activity", act, 1'b1);
    voice <= 1'b0;
    repeat (1000) @(posedge pclk);
    state_is(voice_recorder_pkg::s_rec);
    pin_partner_inst.pulse(1, 3);
    {dir, vte} <= 2'b00;
    pin_partner_inst.pulse(0, 3); // Channel was recorded above
    state_is(voice_recorder_pkg::s_play);
    wait_act(1'b0);
    state_is(voice_recorder_pkg::s_idle);
    policy <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("powered_down", pdn, 1'b0);
    apb(1'b1, voice_recorder_pkg::OFS_CONFIG, 32'h0000_0003);
    pin_partner_inst.peek(1'b1, nib, err);
    chk("data_oe_n", err, 1'b1);
    pin_partner_inst.put_cmd(4'h6);
    pin_partner_inst.put_cmd(4'h9);
    pin_partner_inst.peek(1'b0, nib, err);
    chk("data_oe_n", err, 1'b0);
    chk("busy", nib[0], 1'b1);
    apb(1'b0, voice_recorder_pkg::OFS_HOST, 32'h0000_0000);
    chk("host", rd, 32'h0000_0029);
    chk("busy poll", stuck, 1'b0);
    $display("sequencer and host tests done");
    end_of_test();
  end
endmodule

// >>> voice_recorder_control.sv
// Record/playback sequencer, power policy and nibble host port with APB access
`timescale 1ns/100ps
module voice_recorder_control (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        go_pulse_n,
  input  wire logic        halt_pulse_n,
  input  wire logic        pause_pulse_n,
  input  wire logic        put_strobe_n,
  input  wire logic        fetch_strobe_n,
  input  wire logic        chip_enable_n,
  input  wire logic        sleep_policy_select,
  input  wire logic        rate_select,
  input  wire logic        voice_trigger_enable,
  input  wire logic        direction_select,
  input  wire logic        word_count_sel_lo,
  input  wire logic        word_count_sel_hi,
  input  wire logic        channel_bit0,
  input  wire logic        channel_bit1,
  input  wire logic        channel_bit2,
  input  wire logic        voice_detect,
  input  wire logic [3:0]  data_in,
  output logic      [3:0]  data_out,
  output logic             data_oe_n,
  output logic             activity_flag,
  output logic             powered_down,
  output logic             osc_enable,
  output logic             pullup_enable,
  output logic             sample_tick,
  output logic      [15:0] mem_addr,
  output logic             mem_write,
  output logic             mem_read
);

  voice_recorder_pkg::state_type state;

  logic [voice_recorder_pkg::SYNC_W-1:0] pins;
  logic [voice_recorder_pkg::SYNC_W-1:0] sync_a;
  logic [voice_recorder_pkg::SYNC_W-1:0] sync_b;
  logic [voice_recorder_pkg::SYNC_W-1:0] sync_c;
  logic [voice_recorder_pkg::SYNC_W-1:0] fall;
  logic [1:0]  cfg;
  logic        host_mode;
  logic        single_mem;
  logic        go_fall;
  logic        halt_fall;
  logic        pause_fall;
  logic        go_low;
  logic        ce_ok;
  logic        put_ok;
  logic [1:0]  wsel;
  logic        flex;
  logic [2:0]  chan_sel;
  logic [15:0] start_sel;
  logic [15:0] limit_sel;
  logic [15:0] start_q;
  logic [15:0] limit;
  logic [2:0]  chan_q;
  logic        is_rec;
  logic        at_limit;
  logic        rec_end;
  logic        play_end;
  logic        repeat_now;
  logic        active;
  logic        full;
  logic [9:0]  div_cnt;
  logic [9:0]  div_last;
  logic [10:0] busy_cnt;
  logic        busy;
  logic [3:0]  last_nibble;
  logic [7:0]  nibble_count;
  logic [3:0]  status;
  logic [15:0] stop_addr [8];
  logic        apb_setup;
  logic        apb_write;
  logic        mapped;

  // Channel index from word count selection and channel pins
  function automatic logic [2:0] chan_of(input logic [1:0] ws, input logic [2:0] ca);
    unique case (ws)
      2'b01:   chan_of = {1'b0, ca[2:1]};
      2'b10:   chan_of = {2'b00, ca[2]};
      default: chan_of = ca;
    endcase
  endfunction

  // Per-channel capacity in fixed mode
  function automatic logic [15:0] cap_of(input logic [1:0] ws);
    unique case (ws)
      2'b01:   cap_of = voice_recorder_pkg::AREA_SIZE >> 2;
      2'b10:   cap_of = voice_recorder_pkg::AREA_SIZE >> 1;
      default: cap_of = voice_recorder_pkg::AREA_SIZE >> 3;
    endcase
  endfunction

  // Two-stage synchronisers, third stage only for edge detection
  assign pins = {data_in, voice_detect, channel_bit2, channel_bit1, channel_bit0,
                 word_count_sel_hi, word_count_sel_lo, direction_select,
                 voice_trigger_enable, rate_select, sleep_policy_select, chip_enable_n,
                 fetch_strobe_n, put_strobe_n, pause_pulse_n, halt_pulse_n, go_pulse_n};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= voice_recorder_pkg::SYNC_RESET;
      sync_b <= voice_recorder_pkg::SYNC_RESET;
      sync_c <= voice_recorder_pkg::SYNC_RESET;
    end else begin
      sync_a <= pins;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Falling edges, one cycle each
  assign fall       = sync_c & ~sync_b;
  assign go_fall    = fall[voice_recorder_pkg::PIN_GO];
  assign halt_fall  = fall[voice_recorder_pkg::PIN_HALT];
  assign pause_fall = fall[voice_recorder_pkg::PIN_PAUSE];
  assign go_low     = ~sync_b[voice_recorder_pkg::PIN_GO];
  assign host_mode  = cfg[voice_recorder_pkg::CFG_HOST_BIT];
  assign single_mem = cfg[voice_recorder_pkg::CFG_SINGLE_BIT];

  // Start address and limit of the selected channel
  assign wsel      = sync_b[voice_recorder_pkg::PIN_WSEL +: 2];
  assign flex      = (wsel == 2'b11);
  assign chan_sel  = chan_of(wsel, sync_b[voice_recorder_pkg::PIN_CA +: 3]);
  always_comb begin
    if (flex) begin
      start_sel = (chan_sel == 3'd0) ? voice_recorder_pkg::VOICE_BASE
                : 16'(stop_addr[chan_sel - 3'd1] + 16'd1);
      limit_sel = voice_recorder_pkg::MEM_MAX;
    end else begin
      start_sel = 16'(voice_recorder_pkg::VOICE_BASE
                + cap_of(wsel) * {13'd0, chan_sel});
      limit_sel = 16'(start_sel + cap_of(wsel) - 16'd1);
    end
  end

  // End-of-run events
  assign at_limit   = sample_tick && (mem_addr == limit);
  assign repeat_now = go_low && single_mem;
  assign rec_end    = (state == voice_recorder_pkg::s_rec && (halt_fall || at_limit))
                   || (state == voice_recorder_pkg::s_pause && is_rec && halt_fall);
  assign play_end   = state == voice_recorder_pkg::s_play && at_limit && !repeat_now;

  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= voice_recorder_pkg::s_idle;
    end else begin
      unique case (state)
        voice_recorder_pkg::s_idle: begin
          if (go_fall) begin
            if (!sync_b[voice_recorder_pkg::PIN_DIR]) begin
              state <= voice_recorder_pkg::s_play;
            end else if (sync_b[voice_recorder_pkg::PIN_VTE]) begin
              state <= voice_recorder_pkg::s_wait;
            end else begin
              state <= voice_recorder_pkg::s_rec;
            end
          end
        end
        voice_recorder_pkg::s_wait: begin
          if (halt_fall) begin
            state <= voice_recorder_pkg::s_idle;
          end else if (sync_b[voice_recorder_pkg::PIN_VOICE]) begin
            state <= voice_recorder_pkg::s_rec;
          end
        end
        voice_recorder_pkg::s_rec: begin
          if (rec_end) begin
            state <= voice_recorder_pkg::s_idle;
          end else if (pause_fall) begin
            state <= voice_recorder_pkg::s_pause;
          end
        end
        voice_recorder_pkg::s_play: begin
          if (halt_fall || play_end) begin
            state <= voice_recorder_pkg::s_idle;
          end else if (pause_fall) begin
            state <= voice_recorder_pkg::s_pause;
          end
        end
        voice_recorder_pkg::s_pause: begin
          if (halt_fall) begin
            state <= voice_recorder_pkg::s_idle;
          end else if (go_fall) begin
            state <= is_rec ? voice_recorder_pkg::s_rec
                            : voice_recorder_pkg::s_play;
          end
        end
      endcase
    end
  end

  // Run parameters captured at go; address advances once per sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr <= 16'h0000;
      start_q  <= 16'h0000;
      limit    <= 16'h0000;
      chan_q   <= 3'd0;
      is_rec   <= 1'b0;
    end else if (state == voice_recorder_pkg::s_idle && go_fall) begin
      mem_addr <= start_sel;
      start_q  <= start_sel;
      chan_q   <= chan_sel;
      is_rec   <= sync_b[voice_recorder_pkg::PIN_DIR];
      limit    <= sync_b[voice_recorder_pkg::PIN_DIR] ? limit_sel : stop_addr[chan_sel];
    end else if (sample_tick && (state == voice_recorder_pkg::s_rec
                             || state == voice_recorder_pkg::s_play)) begin
      if (at_limit && state == voice_recorder_pkg::s_play) begin
        mem_addr <= start_q;
      end else if (!at_limit) begin
        mem_addr <= 16'(mem_addr + 16'd1);
      end
    end
  end

  // Stop address table, written when a recording ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        stop_addr[i] <= 16'h0000;
      end
    end else if (rec_end) begin
      stop_addr[chan_q] <= mem_addr;
    end
  end

  // Full flag: a recording, flex or in the last fixed channel, ran to the memory end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full <= 1'b0;
    end else if (state == voice_recorder_pkg::s_rec && at_limit
                 && limit == voice_recorder_pkg::MEM_MAX) begin
      full <= 1'b1;
    end else if (state == voice_recorder_pkg::s_idle && go_fall) begin
      full <= 1'b0;
    end
  end

  // Power policy
  assign active = state != voice_recorder_pkg::s_idle;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powered_down <= 1'b1;
      osc_enable   <= 1'b0;
    end else if (sync_b[voice_recorder_pkg::PIN_POLICY]) begin
      powered_down <= 1'b0;
      osc_enable   <= 1'b1;
    end else begin
      powered_down <= !active;
      osc_enable   <= active;
    end
  end

  // Sample-rate divider, held cleared while powered down
  assign div_last = sync_b[voice_recorder_pkg::PIN_RATE] ? voice_recorder_pkg::DIV_FAST_LAST
                                                          : voice_recorder_pkg::DIV_SLOW_LAST;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt     <= 10'h000;
      sample_tick <= 1'b0;
    end else if (powered_down) begin
      div_cnt     <= 10'h000;
      sample_tick <= 1'b0;
    end else if (div_cnt >= div_last) begin
      div_cnt     <= 10'h000;
      sample_tick <= 1'b1;
    end else begin
      div_cnt     <= 10'(div_cnt + 10'd1);
      sample_tick <= 1'b0;
    end
  end

  // Memory strobes and activity flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_write <= 1'b0;
      mem_read  <= 1'b0;
    end else begin
      mem_write <= sample_tick && state == voice_recorder_pkg::s_rec;
      mem_read  <= sample_tick && state == voice_recorder_pkg::s_play;
    end
  end
  assign activity_flag = state == voice_recorder_pkg::s_rec
                      || state == voice_recorder_pkg::s_play
                      || state == voice_recorder_pkg::s_pause;

  // Pull-ups only in stand-alone operation and out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_enable <= 1'b0;
    end else begin
      pullup_enable <= !host_mode;
    end
  end

  // Host strobes gated by chip enable
  assign ce_ok  = host_mode && !sync_b[voice_recorder_pkg::PIN_CE];
  assign put_ok = ce_ok && fall[voice_recorder_pkg::PIN_PUT];

  // Busy timer: reset processing, then each accepted nibble
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= voice_recorder_pkg::BUSY_RST_CYC;
    end else if (put_ok) begin
      busy_cnt <= voice_recorder_pkg::BUSY_CMD_CYC;
    end else if (busy_cnt != 11'd0) begin
      busy_cnt <= 11'(busy_cnt - 11'd1);
    end
  end
  assign busy = busy_cnt != 11'd0;

  // Nibble latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_nibble  <= 4'h0;
      nibble_count <= 8'h00;
    end else if (put_ok) begin
      last_nibble  <= sync_b[voice_recorder_pkg::PIN_DATA +: 4];
      nibble_count <= 8'(nibble_count + 8'd1);
    end
  end

  // Status nibble and data line drive
  assign status = {full, state == voice_recorder_pkg::s_wait || state == voice_recorder_pkg::s_pause,
                   state == voice_recorder_pkg::s_rec || state == voice_recorder_pkg::s_play, busy};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out <= 4'h0;
    end else begin
      data_out <= status;
    end
  end
  assign data_oe_n = !(ce_ok && !sync_b[voice_recorder_pkg::PIN_FETCH]);

  // APB slave, zero wait states
  assign pready    = 1'b1;
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  assign mapped    = paddr == voice_recorder_pkg::OFS_CONFIG
                  || paddr == voice_recorder_pkg::OFS_STATUS
                  || paddr == voice_recorder_pkg::OFS_HOST;
  assign pslverr   = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= voice_recorder_pkg::CFG_RESET;
    end else if (apb_write && paddr == voice_recorder_pkg::OFS_CONFIG) begin
      cfg <= pwdata[1:0];
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      unique case (paddr)
        voice_recorder_pkg::OFS_CONFIG: prdata <= {30'd0, cfg};
        voice_recorder_pkg::OFS_STATUS: prdata <= {mem_addr, 7'd0, state, status};
        voice_recorder_pkg::OFS_HOST:   prdata <= {20'd0, nibble_count, last_nibble};
        default:                        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_record_start: assert property (
    state == voice_recorder_pkg::s_idle && go_fall && sync_b[voice_recorder_pkg::PIN_DIR]
    && !sync_b[voice_recorder_pkg::PIN_VTE] |=> state == voice_recorder_pkg::s_rec
    ##0 activity_flag)
    else $error("record did not start on go");

  a_halt_stops: assert property (
    activity_flag && halt_fall |=> state == voice_recorder_pkg::s_idle ##1 !activity_flag)
    else $error("halt did not stop the run");

  a_pause_suspend: assert property (
    (state == voice_recorder_pkg::s_rec || state == voice_recorder_pkg::s_play)
    && pause_fall && !halt_fall && !at_limit |=> state == voice_recorder_pkg::s_pause)
    else $error("pause did not suspend");

  a_resume_direct: assert property (
    state == voice_recorder_pkg::s_pause && is_rec && go_fall && !halt_fall
    |=> state == voice_recorder_pkg::s_rec)
    else $error("resume went through voice wait");

  a_voice_wait: assert property (
    state == voice_recorder_pkg::s_wait |-> !activity_flag ##1
    ($past(halt_fall) ? state == voice_recorder_pkg::s_idle : 1'b1))
    else $error("voice wait misbehaved");

  a_tick_spacing: assert property (
    sample_tick |=> !sample_tick [*8])
    else $error("sample ticks too close");

  a_sleep_auto: assert property (
    !sync_b[voice_recorder_pkg::PIN_POLICY] && state == voice_recorder_pkg::s_idle
    |=> powered_down && !osc_enable)
    else $error("idle did not power down");

  a_sleep_standby: assert property (
    sync_b[voice_recorder_pkg::PIN_POLICY] |=> !powered_down && osc_enable)
    else $error("standby policy powered down");

  a_ce_release: assert property (
    sync_b[voice_recorder_pkg::PIN_CE] |-> data_oe_n && !put_ok)
    else $error("strobe honoured with chip disabled");

  a_busy_after_put: assert property (
    put_ok |=> busy [*8])
    else $error("busy not raised after nibble");

endmodule

// >>> voice_recorder_pkg.sv
// Constants and types shared by the voice recorder control block
package voice_recorder_pkg;
  // APB register offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_HOST   = 8'h08;
  // Config fields and reset value
  localparam int CFG_HOST_BIT = 0;
  localparam int CFG_SINGLE_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h2;
  // Positions of the synchronised pin inputs
  localparam int PIN_GO = 0;
  localparam int PIN_HALT = 1;
  localparam int PIN_PAUSE = 2;
  localparam int PIN_PUT = 3;
  localparam int PIN_FETCH = 4;
  localparam int PIN_CE = 5;
  localparam int PIN_POLICY = 6;
  localparam int PIN_RATE = 7;
  localparam int PIN_VTE = 8;
  localparam int PIN_DIR = 9;
  localparam int PIN_WSEL = 10;
  localparam int PIN_CA = 12;
  localparam int PIN_VOICE = 15;
  localparam int PIN_DATA = 16;
  localparam int SYNC_W = 20;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 20'h0_003F;
  // Sample-rate dividers, terminal counts
  localparam logic [9:0] DIV_SLOW_LAST = 10'h2FF;
  localparam logic [9:0] DIV_FAST_LAST = 10'h1FF;
  // Memory map of the serial register store
  localparam logic [15:0] VOICE_BASE = 16'h0010;
  localparam logic [15:0] MEM_MAX = 16'hFFFF;
  localparam logic [15:0] AREA_SIZE = 16'hFFF0;
  // Busy times
  localparam int CLK_NS = 100;
  localparam int BUSY_CMD_NS = 16000;
  localparam int BUSY_RST_NS = 125000;
  localparam logic [10:0] BUSY_CMD_CYC = 11'((BUSY_CMD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] BUSY_RST_CYC = 11'((BUSY_RST_NS + CLK_NS - 1) / CLK_NS);
  // Sequencer states
  typedef enum logic [4:0] {
    s_idle  = 5'b00001,
    s_wait  = 5'b00010,
    s_rec   = 5'b00100,
    s_play  = 5'b01000,
    s_pause = 5'b10000
  } state_type;
endpackage
